//--- design/lucp_pkg.sv
// Purpose: Shared constants for the line unit status, cable and pulse register slice.
// Assumes: APB slave with 32-bit data; each register takes one aligned word.
// Notes: Register offsets are word indices; the byte address is four times the index.
package lucp_pkg;

    // APB geometry
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 32;

    // Register word indices
    localparam logic [11:0] IDX_LINE_CONTROL = 12'hF00;
    localparam logic [11:0] IDX_ENABLE = 12'hF04;
    localparam logic [11:0] IDX_STATUS = 12'hF05;
    localparam logic [11:0] IDX_CHANGE_FLAGS = 12'hF06;
    localparam logic [11:0] IDX_CABLE_ATTEN = 12'hF07;
    localparam logic [11:0] IDX_PULSE_SEG_ONE = 12'hF08;
    localparam logic [11:0] IDX_LINE_CONFIG = 12'hF10;

    // Field positions
    localparam int unsigned BIT_PATTERN_LOCK = 0;
    localparam int unsigned BIT_LOS = 1;
    localparam int unsigned BIT_SINGLE_RAIL = 0;
    localparam int unsigned BIT_EXT_LOSS = 1;
    localparam int unsigned BIT_SEG_SIGN = 6;
    localparam int unsigned EQSEL_W = 5;
    localparam int unsigned CABLE_W = 6;
    localparam int unsigned SEG_W = 7;
    localparam int unsigned EVT_W = 2;

    // Equalizer select code that picks arbitrary pulse mode
    localparam logic [4:0] EQSEL_ARBITRARY = 5'h1F;

    // Values after reset
    localparam logic [4:0] RST_EQSEL = 5'h00;
    localparam logic [1:0] RST_ENABLE = 2'h0;
    localparam logic [1:0] RST_FLAGS = 2'h0;
    localparam logic [1:0] RST_LIVE = 2'h0;
    localparam logic [5:0] RST_CABLE = 6'h00;
    localparam logic [6:0] RST_SEG = 7'h00;
    localparam logic RST_SINGLE_RAIL = 1'b0;
    localparam logic RST_EXT_LOSS = 1'b0;

    // Cycles from penable to pready high in the access phase
    localparam int unsigned APB_WAIT_CYCLES = 1;

endpackage : lucp_pkg

//--- design/lucp_regs.sv
// Purpose: Change flags, cable attenuation code and first pulse segment registers.
// Assumes: Live status and attenuation inputs are synchronous to ref_clk.
// Notes: APB slave inserts one wait state so every answer comes from a flip-flop.
//
// Contract
// - Loss change sets flag bit 1, read clears.
// - Pattern-lock change sets flag bit 0, read clears.
// - Status logic works only in single rail.
// - Read-only six-bit cable attenuation code.
// - First segment drives pulse in arbitrary mode.
// - Segment is signed magnitude, bit 6 sign.
// - Arbitrary mode only via equalizer select code.
// - Loss enable bit 1 raises interrupt on change.
// - Pattern enable bit 0 raises interrupt on change.
`timescale 1ns/1ps
`default_nettype none

module lucp_regs (
    input wire logic ref_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [lucp_pkg::ADDR_W-1:0] paddr,
    input wire logic [lucp_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [lucp_pkg::DATA_W-1:0] prdata,
    output logic pslverr,
    // Live receive side
    input wire logic receive_signal_loss,
    input wire logic pattern_lock_status,
    input wire logic [lucp_pkg::CABLE_W-1:0] cable_attenuation_code,
    // Controls toward the line circuits
    output logic [lucp_pkg::EQSEL_W-1:0] equalizer_select,
    output logic arbitrary_mode,
    output logic first_pulse_sign,
    output logic [lucp_pkg::SEG_W-2:0] first_pulse_magnitude,
    output logic single_rail,
    output logic extended_loss_option,
    output logic irq
);

    typedef struct packed {
        logic [lucp_pkg::EQSEL_W-1:0] eqsel;
        logic single_rail;
        logic ext_loss;
        logic [lucp_pkg::EVT_W-1:0] enable;
        logic [lucp_pkg::EVT_W-1:0] live;
        logic [lucp_pkg::EVT_W-1:0] flags;
        logic [lucp_pkg::CABLE_W-1:0] cable;
        logic [lucp_pkg::SEG_W-1:0] seg1;
        logic arb_mode;
        logic seg_sign;
        logic [lucp_pkg::SEG_W-2:0] seg_mag;
        logic irq;
        logic pready;
        logic [lucp_pkg::DATA_W-1:0] prdata;
        logic pslverr;
    } lucp_state_t;

    lucp_state_t s_q;
    lucp_state_t s_d;

    // Word index compare; low two address bits must be zero for a hit
    function automatic logic lucp_hit(
        input logic [lucp_pkg::ADDR_W-1:0] addr,
        input logic [11:0] idx
    );
        lucp_hit = (addr[1:0] == 2'h0) && (addr[lucp_pkg::ADDR_W-1:2] == {2'h0, idx});
    endfunction : lucp_hit

    // Register behind an address; unaligned or unlisted words decode to none
    typedef enum {
        REG_NONE,
        REG_LINE_CONTROL,
        REG_ENABLE,
        REG_STATUS,
        REG_CHANGE_FLAGS,
        REG_CABLE_ATTEN,
        REG_PULSE_SEG_ONE,
        REG_LINE_CONFIG
    } lucp_reg_t;

    function automatic lucp_reg_t lucp_decode(
        input logic [lucp_pkg::ADDR_W-1:0] addr
    );
        lucp_decode = REG_NONE;
        if (lucp_hit(addr, lucp_pkg::IDX_LINE_CONTROL)) begin
            lucp_decode = REG_LINE_CONTROL;
        end
        if (lucp_hit(addr, lucp_pkg::IDX_ENABLE)) begin
            lucp_decode = REG_ENABLE;
        end
        if (lucp_hit(addr, lucp_pkg::IDX_STATUS)) begin
            lucp_decode = REG_STATUS;
        end
        if (lucp_hit(addr, lucp_pkg::IDX_CHANGE_FLAGS)) begin
            lucp_decode = REG_CHANGE_FLAGS;
        end
        if (lucp_hit(addr, lucp_pkg::IDX_CABLE_ATTEN)) begin
            lucp_decode = REG_CABLE_ATTEN;
        end
        if (lucp_hit(addr, lucp_pkg::IDX_PULSE_SEG_ONE)) begin
            lucp_decode = REG_PULSE_SEG_ONE;
        end
        if (lucp_hit(addr, lucp_pkg::IDX_LINE_CONFIG)) begin
            lucp_decode = REG_LINE_CONFIG;
        end
    endfunction : lucp_decode

    function automatic logic lucp_mapped(
        input lucp_reg_t sel
    );
        lucp_mapped = (sel != REG_NONE);
    endfunction : lucp_mapped

    // Reserved bits stay zero; every register sits in the low byte
    // Every decode value is listed, so the case needs no default
    function automatic logic [lucp_pkg::DATA_W-1:0] lucp_read_word(
        input lucp_state_t s,
        input lucp_reg_t sel
    );
        lucp_read_word = '0;
        unique case (sel)
            REG_LINE_CONTROL: begin
                lucp_read_word[lucp_pkg::EQSEL_W-1:0] = s.eqsel;
            end
            REG_ENABLE: begin
                lucp_read_word[lucp_pkg::EVT_W-1:0] = s.enable;
            end
            REG_STATUS: begin
                lucp_read_word[lucp_pkg::EVT_W-1:0] = s.live;
            end
            REG_CHANGE_FLAGS: begin
                lucp_read_word[lucp_pkg::EVT_W-1:0] = s.flags;
            end
            REG_CABLE_ATTEN: begin
                lucp_read_word[lucp_pkg::CABLE_W-1:0] = s.cable;
            end
            REG_PULSE_SEG_ONE: begin
                lucp_read_word[lucp_pkg::SEG_W-1:0] = s.seg1;
            end
            REG_LINE_CONFIG: begin
                lucp_read_word[lucp_pkg::BIT_SINGLE_RAIL] = s.single_rail;
                lucp_read_word[lucp_pkg::BIT_EXT_LOSS] = s.ext_loss;
            end
            REG_NONE: begin
                lucp_read_word = '0;
            end
        endcase
    endfunction : lucp_read_word

    // Bus handshake
    logic access_start;
    logic access_done;
    logic wr_done;
    logic rd_done;
    logic wr_lane;
    logic wr_take;
    logic rd_clear;
    lucp_reg_t sel;
    logic [lucp_pkg::DATA_W-1:0] rd_word;
    // Event path
    logic [lucp_pkg::EVT_W-1:0] live_now;
    logic [lucp_pkg::EVT_W-1:0] change;
    logic [lucp_pkg::EVT_W-1:0] clear;
    logic [lucp_pkg::EVT_W-1:0] flag_next;
    logic [lucp_pkg::EVT_W-1:0] pending;

    // Live status sampled every cycle so software sees current state
    assign live_now[lucp_pkg::BIT_LOS] = receive_signal_loss;
    assign live_now[lucp_pkg::BIT_PATTERN_LOCK] = pattern_lock_status;

    // Either edge counts as a change; ignored outside single rail
    // Set wins over clear so a change in the clearing cycle survives
    for (genvar gi = 0; gi < lucp_pkg::EVT_W; gi++) begin : g_flag
        assign change[gi] = (s_q.live[gi] ^ live_now[gi]) && s_q.single_rail;
        assign flag_next[gi] = change[gi] || (s_q.flags[gi] && !clear[gi]);
    end

    always_comb begin
        s_d = s_q;
        clear = '0;

        // Decode once; the read mux and the write case share it
        sel = lucp_decode(paddr);
        access_start = psel && penable && !s_q.pready;
        access_done = psel && penable && s_q.pready;
        wr_lane = pstrb[0];
        wr_done = access_done && pwrite && lucp_mapped(sel);
        rd_done = access_done && !pwrite && lucp_mapped(sel);
        wr_take = wr_done && wr_lane;
        rd_clear = rd_done && (sel == REG_CHANGE_FLAGS);
        rd_word = lucp_read_word(s_q, sel);

        // One wait state: a registered answer keeps prdata off the address decode
        if (access_start) begin
            s_d.pready = 1'b1;
            s_d.prdata = pwrite ? '0 : rd_word;
            s_d.pslverr = !lucp_mapped(sel);
        end
        if (access_done) begin
            s_d.pready = 1'b0;
            s_d.prdata = '0;
            s_d.pslverr = 1'b0;
        end

        // Writes land only at the completing edge, low byte lane only
        if (wr_take) begin
            unique case (sel)
                REG_LINE_CONTROL: begin
                    s_d.eqsel = pwdata[lucp_pkg::EQSEL_W-1:0];
                end
                REG_ENABLE: begin
                    s_d.enable = pwdata[lucp_pkg::EVT_W-1:0];
                end
                REG_PULSE_SEG_ONE: begin
                    s_d.seg1 = pwdata[lucp_pkg::SEG_W-1:0];
                end
                REG_LINE_CONFIG: begin
                    s_d.single_rail = pwdata[lucp_pkg::BIT_SINGLE_RAIL];
                    // Needed by sync interface mode; fixes 4096-bit loss detection
                    s_d.ext_loss = pwdata[lucp_pkg::BIT_EXT_LOSS];
                end
                // Writing ones clears the matching flags
                REG_CHANGE_FLAGS: begin
                    clear = pwdata[lucp_pkg::EVT_W-1:0];
                end
                // Read-only and unmapped words ignore writes
                REG_NONE, REG_STATUS, REG_CABLE_ATTEN: begin
                    clear = '0;
                end
            endcase
        end

        // A read of the flag register clears every flag
        if (rd_clear) begin
            clear = '1;
        end

        s_d.live = live_now;
        // Attenuation code tracks the equalizer continuously
        s_d.cable = cable_attenuation_code;
        s_d.flags = flag_next;

        // Segment only reaches the pulse shaper in arbitrary mode
        s_d.arb_mode = (s_d.eqsel == lucp_pkg::EQSEL_ARBITRARY);
        if (s_d.arb_mode) begin
            s_d.seg_sign = s_d.seg1[lucp_pkg::BIT_SEG_SIGN];
            s_d.seg_mag = s_d.seg1[lucp_pkg::SEG_W-2:0];
        end else begin
            s_d.seg_sign = 1'b0;
            s_d.seg_mag = '0;
        end

        // Level interrupt; software masks loss here for its own method
        // Only flags that pass the enable mask count
        pending = s_d.flags & s_d.enable;
        s_d.irq = s_d.single_rail && |pending;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q.eqsel <= lucp_pkg::RST_EQSEL;
            s_q.single_rail <= lucp_pkg::RST_SINGLE_RAIL;
            s_q.ext_loss <= lucp_pkg::RST_EXT_LOSS;
            s_q.enable <= lucp_pkg::RST_ENABLE;
            s_q.live <= lucp_pkg::RST_LIVE;
            s_q.flags <= lucp_pkg::RST_FLAGS;
            s_q.cable <= lucp_pkg::RST_CABLE;
            s_q.seg1 <= lucp_pkg::RST_SEG;
            s_q.arb_mode <= 1'b0;
            s_q.seg_sign <= 1'b0;
            s_q.seg_mag <= '0;
            s_q.irq <= 1'b0;
            s_q.pready <= 1'b0;
            s_q.prdata <= '0;
            s_q.pslverr <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pready = s_q.pready;
    assign prdata = s_q.prdata;
    assign pslverr = s_q.pslverr;
    assign equalizer_select = s_q.eqsel;
    assign arbitrary_mode = s_q.arb_mode;
    assign first_pulse_sign = s_q.seg_sign;
    assign first_pulse_magnitude = s_q.seg_mag;
    assign single_rail = s_q.single_rail;
    assign extended_loss_option = s_q.ext_loss;
    assign irq = s_q.irq;

endmodule : lucp_regs

`default_nettype wire

//--- dv/lucp_regs_assertions.sv
// Purpose: Port checks for the line unit register slice.
// Assumes: Byte address is four times the word index.
// Notes: Enable bits are mirrored from taken writes, as they have no port.
`timescale 1ns/1ps
`default_nettype none
module lucp_regs_chk (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic receive_signal_loss,
    input wire logic pattern_lock_status,
    input wire logic [5:0] cable_attenuation_code,
    input wire logic [4:0] equalizer_select,
    input wire logic arbitrary_mode,
    input wire logic first_pulse_sign,
    input wire logic [5:0] first_pulse_magnitude,
    input wire logic single_rail,
    input wire logic irq
);
    logic [1:0] en_q;
    wire logic take = psel && penable && pready;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            en_q <= 2'h0;
        end else if (take && pwrite && pstrb[0] && paddr == 16'h3C10) begin
            en_q <= pwdata[1:0];
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence read_s(logic [15:0] a);
        take && !pwrite && paddr == a;
    endsequence
    err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error answer not clean");
    seg_rsvd_a: assert property (read_s(16'h3C20) |-> prdata[31:7] == 25'h0)
        else $error("segment spare bits set");
    cable_read_a: assert property (read_s(16'h3C1C) ##0
        cable_attenuation_code == $past(cable_attenuation_code, 3) |->
        prdata == {26'h0, cable_attenuation_code}) else $error("cable code wrong");
    arb_mode_a: assert property (arbitrary_mode ==
        (equalizer_select == lucp_pkg::EQSEL_ARBITRARY)) else $error("mode wrong");
    seg_gate_a: assert property (!arbitrary_mode |->
        !first_pulse_sign && first_pulse_magnitude == 6'h0) else $error("segment leaks");
    irq_rail_a: assert property (irq |-> single_rail)
        else $error("irq outside single rail");
    los_irq_a: assert property (single_rail && en_q[1] &&
        $changed(receive_signal_loss) |-> ##[1:3] irq) else $error("no loss irq");
    lock_irq_a: assert property (single_rail && en_q[0] &&
        $changed(pattern_lock_status) |-> ##[1:3] irq) else $error("no lock irq");
endmodule : lucp_regs_chk
bind lucp_regs lucp_regs_chk chk_i (.*);
`default_nettype wire

//--- dv/lucp_host.sv
// Purpose: Host model issuing APB transfers.
// Assumes: Called right after a rising edge.
// Notes: One idle edge after each transfer avoids double drives.
`timescale 1ns/1ps
`default_nettype none
module lucp_host (
    input wire logic ref_clk,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    output var logic psel = 1'b0,
    output var logic penable = 1'b0,
    output var logic pwrite = 1'b0,
    output var logic [15:0] paddr = 16'h0000,
    output var logic [31:0] pwdata = 32'h00000000,
    output var logic [3:0] pstrb = 4'hF
);
    task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : xfer
endmodule : lucp_host
`default_nettype wire

//--- dv/lucp_regs_bench.sv
// Purpose: Self-checking bench for the line unit register slice.
// Assumes: Host model drives the APB side.
// Notes: Waits after events follow the one-edge flag and irq latency.
`timescale 1ns/1ps
`default_nettype none
module lucp_regs_bench;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, err;
    logic receive_signal_loss, pattern_lock_status, arbitrary_mode, first_pulse_sign;
    logic single_rail, extended_loss_option, irq;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [5:0] cable_attenuation_code, first_pulse_magnitude;
    logic [4:0] equalizer_select;
    int fail_count = 0;
    int num_checks = 0;
    lucp_regs dut (.*);
    lucp_host host (.*);
    always #2 ref_clk = ~ref_clk;
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rd, err);
        @(posedge ref_clk);
    endtask : wr
    task automatic rd_chk(input string what, input logic [15:0] a, input logic [31:0] exp);
        host.xfer(1'b0, a, 32'h0, rd, err);
        chk(what, exp, rd);
    endtask : rd_chk
    task automatic settle;
        repeat (4) @(posedge ref_clk);
    endtask : settle
    task automatic t_reset;
        rd_chk("flags", 16'h3C18, 32'h0);
        rd_chk("cable", 16'h3C1C, 32'h0);
        rd_chk("seg", 16'h3C20, 32'h0);
        rd_chk("unmapped", 16'h3C24, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
    endtask : t_reset
    task automatic t_pulse;
        wr(16'h3C20, 32'hFF);
        rd_chk("seg", 16'h3C20, 32'h7F);
        wr(16'h3C00, 32'h1F);
        chk("eqsel", 32'h1F, {27'h0, equalizer_select});
        chk("arb", 32'h1, {31'h0, arbitrary_mode});
        chk("pulse", 32'h7F, {25'h0, first_pulse_sign, first_pulse_magnitude});
        wr(16'h3C20, 32'h05);
        chk("pulse", 32'h05, {25'h0, first_pulse_sign, first_pulse_magnitude});
        wr(16'h3C00, 32'h1E);
        chk("arb", 32'h0, {31'h0, arbitrary_mode});
        chk("pulse", 32'h0, {25'h0, first_pulse_sign, first_pulse_magnitude});
    endtask : t_pulse
    task automatic t_flags;
        wr(16'h3C40, 32'h3);
        wr(16'h3C10, 32'h3);
        chk("rail", 32'h3, {30'h0, extended_loss_option, single_rail});
        rd_chk("enable", 16'h3C10, 32'h3);
        receive_signal_loss <= 1'b1;
        settle();
        chk("irq", 32'h1, {31'h0, irq});
        rd_chk("status", 16'h3C14, 32'h2);
        rd_chk("flags", 16'h3C18, 32'h2);
        rd_chk("flags", 16'h3C18, 32'h0);
        settle();
        chk("irq", 32'h0, {31'h0, irq});
        pattern_lock_status <= 1'b1;
        settle();
        chk("irq", 32'h1, {31'h0, irq});
        rd_chk("flags", 16'h3C18, 32'h1);
        wr(16'h3C10, 32'h1);
        receive_signal_loss <= 1'b0;
        settle();
        chk("irq", 32'h0, {31'h0, irq});
        rd_chk("flags", 16'h3C18, 32'h2);
    endtask : t_flags
    task automatic t_race;
        fork
            rd_chk("flags", 16'h3C18, 32'h0);
            begin
                repeat (2) @(posedge ref_clk);
                receive_signal_loss <= 1'b1;
            end
        join
        rd_chk("flags", 16'h3C18, 32'h2);
    endtask : t_race
    task automatic t_cable;
        cable_attenuation_code <= 6'h2A;
        settle();
        wr(16'h3C1C, 32'h3F);
        rd_chk("cable", 16'h3C1C, 32'h2A);
    endtask : t_cable
    task automatic t_rail;
        wr(16'h3C40, 32'h0);
        receive_signal_loss <= 1'b0;
        settle();
        rd_chk("flags", 16'h3C18, 32'h0);
    endtask : t_rail
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        receive_signal_loss = 1'b0;
        pattern_lock_status = 1'b0;
        cable_attenuation_code = 6'h00;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        t_reset();
        t_pulse();
        t_flags();
        t_race();
        t_cable();
        t_rail();
        tally_and_finish();
    end
    initial begin
        #20000;
        fail_count++;
        tally_and_finish();
    end
endmodule : lucp_regs_bench
`default_nettype wire
